// ---- dv/psr_transfer_unit_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module psr_transfer_unit_tb;
  logic        clk_i = 0, rst_n_i = 0, instr_valid_i = 0, mode_load_i = 0;
  logic [31:0] instr_i = 0, reg_value_i, current_status_reg_o;
  logic [31:0] saved_status_reg_o, result_o;
  logic [4:0]  mode_load_value_i = 0, mode_o;
  logic [3:0]  reg_index_o, result_index_o;
  logic        result_we_o, done_o, illegal_o;
  int          n_fail = 0, num_checks = 0;
  always #20 clk_i = ~clk_i;
  psr_transfer_unit u_psr_transfer_unit (.clk_i, .rst_n_i, .instr_valid_i,
    .instr_i, .reg_value_i, .mode_load_i, .mode_load_value_i,
    .current_status_reg_o, .saved_status_reg_o, .mode_o, .reg_index_o,
    .result_o, .result_we_o, .result_index_o, .done_o, .illegal_o);
  psrtu_sw_model u_psrtu_sw_model (.clk_i, .rd_idx_i(instr_i[3:0]),
    .we_i(result_we_o), .wr_idx_i(result_index_o), .wr_data_i(result_o),
    .rd_data_o(reg_value_i));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
      n_fail++;
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // software never puts an 8-bit immediate into the whole register
  task automatic issue(input logic [31:0] w, input bit good);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    instr_i       <= 32'h0000_0000;
    #1;
    if (good) chk(done_o, 1);
    else chk(illegal_o, 1);
    chk(reg_index_o, {28'h000_0000, w[3:0]});
  endtask
  task automatic enter_mode(input logic [4:0] m);
    @(posedge clk_i);
    mode_load_i       <= 1'b1;
    mode_load_value_i <= m;
    @(posedge clk_i);
    mode_load_i       <= 1'b0;
    #1;
    chk(mode_o, m);
  endtask
  task automatic t_flags;
    chk(current_status_reg_o, 32'h0000_00D3);
    chk(mode_o, 5'h13);
    issue(32'hE328_F4F0, 1);
    chk(current_status_reg_o, 32'hF000_00D3);
    u_psrtu_sw_model.regs_q[3] = 32'hA5A5_5A5A;
    issue(32'hE128_F003, 1);
    chk(current_status_reg_o, 32'hA000_00D3);
  endtask
  task automatic t_rmw;
    issue(32'hE10F_0000, 1);
    chk(result_o, 32'hA000_00D3);
    chk(result_index_o, 4'h0);
    chk(result_we_o, 1'b1);
    @(posedge clk_i);
    #1;
    // only the mode field is touched, reserved bits ride along
    u_psrtu_sw_model.regs_q[0] =
      (u_psrtu_sw_model.regs_q[0] & ~32'h0000_001F) | 32'h0000_0010;
    issue(32'hE129_F000, 1);
    chk(current_status_reg_o, 32'hA000_00D0);
    chk(mode_o, 5'h10);
  endtask
  task automatic t_user;
    u_psrtu_sw_model.regs_q[1] = 32'h5000_00D3;
    issue(32'hE129_F001, 1);
    chk(current_status_reg_o, 32'h5000_00D0);
    issue(32'hE14F_0000, 0);
    issue(32'hE129_F011, 0);
    chk(current_status_reg_o, 32'h5000_00D0);
  endtask
  task automatic t_saved;
    enter_mode(5'h11);
    u_psrtu_sw_model.regs_q[2] = 32'h2000_0013;
    issue(32'hE169_F002, 1);
    @(posedge clk_i);
    #1;
    chk(saved_status_reg_o, 32'h2000_0013);
    chk(current_status_reg_o, 32'h5000_00D1);
    issue(32'hE14F_1000, 1);
    chk(result_o, 32'h2000_0013);
    chk(result_index_o, 32'h0000_0001);
    // a second bank must start clean and take a flag-only immediate
    enter_mode(5'h12);
    issue(32'hE368_F4C0, 1);
    @(posedge clk_i);
    #1;
    chk(saved_status_reg_o, 32'hC000_0000);
    chk(current_status_reg_o, 32'h5000_00D2);
  endtask
  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    t_flags();
    t_rmw();
    t_user();
    t_saved();
    final_report();
  end
endmodule // psr_transfer_unit_tb
`default_nettype wire

// ---- dv/psrtu_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// transfer checker
// ****
module psrtu_sva
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] reg_value_i,
  input wire logic        mode_load_i,
  input wire logic [4:0]  mode_load_value_i,
  input wire logic [31:0] current_status_reg_o,
  input wire logic [4:0]  mode_o,
  input wire logic [31:0] result_o,
  input wire logic        result_we_o,
  input wire logic [3:0]  result_index_o,
  input wire logic        done_o,
  input wire logic        illegal_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] cs;
  logic        tk, bad, ok, fc, wu;
  assign cs = current_status_reg_o;
  assign tk = instr_valid_i && !mode_load_i && instr_i[27:26] == 2'b00
              && instr_i[24:23] == 2'b10 && !instr_i[20]
              && (instr_i[21] || !instr_i[25]);
  assign bad = tk && instr_i[21] && !instr_i[25] && instr_i[11:4] != 8'h00;
  // saved target has no bank in user or system mode
  assign ok = tk && !bad
              && !(instr_i[22] && (mode_o == 5'h10 || mode_o == 5'h1F));
  assign fc = ok && instr_i[21] && !instr_i[22] && !instr_i[16];
  assign wu = ok && instr_i[21] && !instr_i[22] && instr_i[16]
              && mode_o == 5'h10 && !instr_i[25];
  property p_mode;
    mode_load_i |=> mode_o == $past(mode_load_value_i)
      && mode_o == cs[4:0];
  endproperty
  a_mode: assert property (p_mode) else $error("mode load wrong");
  property p_resv; (cs & 32'h0FFF_FF00) == 32'h0000_0000; endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_done; ok |=> done_o && !illegal_o; endproperty
  a_done: assert property (p_done) else $error("transfer not done");
  property p_ctrl; fc |=> cs[27:0] == $past(cs[27:0]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control moved");
  property p_flag;
    fc && !instr_i[25] |=> cs[31:28] == $past(reg_value_i[31:28]);
  endproperty
  a_flag: assert property (p_flag) else $error("flag load wrong");
  property p_user;
    wu |=> cs == {$past(reg_value_i[31:28]), $past(cs[27:0])};
  endproperty
  a_user: assert property (p_user) else $error("user write wrong");
  property p_read;
    ok && !instr_i[21] && !instr_i[22] |=> result_we_o
      && result_o == $past(cs) && result_index_o == $past(instr_i[15:12]);
  endproperty
  a_read: assert property (p_read) else $error("read result wrong");
  property p_bad; bad |=> illegal_o && $stable(cs); endproperty
  a_bad: assert property (p_bad) else $error("bad form accepted");
endmodule // psrtu_sva
bind psr_transfer_unit psrtu_sva u_psrtu_sva (.clk_i, .rst_n_i,
  .instr_valid_i, .instr_i, .reg_value_i, .mode_load_i,
  .mode_load_value_i,
  .current_status_reg_o, .mode_o, .result_o, .result_we_o,
  .result_index_o, .done_o, .illegal_o);
`default_nettype wire

// ---- dv/psrtu_sw_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****
// general register file of the software side
// ****
module psrtu_sw_model
(
  input  wire logic        clk_i,
  input  wire logic [3:0]  rd_idx_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  wr_idx_i,
  input  wire logic [31:0] wr_data_i,
  output logic      [31:0] rd_data_o
);
  logic [31:0] regs_q [16];
  initial for (int i = 0; i < 16; i++) regs_q[i] = 32'h0000_0000;
  // read result lands here so software can modify it and write back
  always @(posedge clk_i) if (we_i === 1'b1) regs_q[wr_idx_i] <= wr_data_i;
  assign rd_data_o = regs_q[rd_idx_i];
endmodule // psrtu_sw_model
`default_nettype wire

// ---- verilog/psr_transfer_unit.sv ----
// Functional notes
// - only N,Z,C,V,I,F,T and the mode field are stored; rest reserved.
// - the mode field is bits 4..0 and writing a new code changes mode.
// - a flag-only write changes N, Z, C, V and leaves control bits alone.
// - a flag-only immediate with top nibble all ones sets all four flags.
// - a flag-only write loads source bits 31..28 into N, Z, C, V in order.
// - user mode whole writes to the current register alter only 31..28.
// - each transfer completes in one cycle; one presented in the same cycle as mode_load_i is dropped.
`timescale 1ns/10ps
`default_nettype none
`include "psrtu_params.svh"

module psr_transfer_unit
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        instr_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] reg_value_i,
  input  wire logic        mode_load_i,
  input  wire logic [4:0]  mode_load_value_i,
  output logic      [31:0] current_status_reg_o,
  output logic      [31:0] saved_status_reg_o,
  output logic      [4:0]  mode_o,
  output logic      [3:0]  reg_index_o,
  output logic      [31:0] result_o,
  output logic             result_we_o,
  output logic      [3:0]  result_index_o,
  output logic             done_o,
  output logic             illegal_o
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [31:0] operand;
  logic        form_ok;
  logic [3:0]  src_index;

  psrtu_operand u_operand
  (
    .instr_i     (instr_i),
    .reg_value_i (reg_value_i),
    .operand_o   (operand),
    .reg_index_o (src_index),
    .form_ok_o   (form_ok)
  );

  function automatic psrtu_pkg::psrtu_op_e classify(input logic [31:0] i);
    if (i[27:26] == 2'b00 && i[24:23] == 2'b10 && i[20] == 1'b0)
    begin
      if (i[21] == 1'b0 && i[25] == 1'b0)
        classify = psrtu_pkg::PSRTU_OP_READ;
      else if (i[21] == 1'b1)
        classify = psrtu_pkg::PSRTU_OP_WRITE;
      else
        classify = psrtu_pkg::PSRTU_OP_NONE;
    end
    else
      classify = psrtu_pkg::PSRTU_OP_NONE;
  endfunction

  // banked saved registers: fiq, irq, svc, abt, und
  function automatic logic [2:0] bank_of(input logic [4:0] m);
    unique case (m)
      `PSRTU_MODE_FIQ: bank_of = 3'd0;
      `PSRTU_MODE_IRQ: bank_of = 3'd1;
      `PSRTU_MODE_SVC: bank_of = 3'd2;
      `PSRTU_MODE_ABT: bank_of = 3'd3;
      `PSRTU_MODE_UND: bank_of = 3'd4;
      default:         bank_of = 3'd7;
    endcase
  endfunction

  // reserved bits are never stored and read back as zero
  function automatic logic [31:0] keep_defined(input logic [31:0] v);
    keep_defined = v & `PSRTU_DEFINED_MASK;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] cur_q, cur_d;
  logic [31:0] saved_status_reg_q [5];
  logic [31:0] saved_status_reg_d [5];
  logic [31:0] result_q, result_d;
  logic        we_q, we_d;
  logic [3:0]  ridx_q, ridx_d;
  logic        done_q, done_d;
  logic        ill_q, ill_d;

  psrtu_pkg::psrtu_op_e op;
  logic [2:0]  bank;
  logic        has_saved;
  logic        to_saved;
  logic        flag_only;
  logic        user_mode;
  logic [31:0] target_old;
  logic [31:0] write_mask;
  logic [31:0] target_new;

  always_comb
  begin
    op         = classify(instr_i);
    bank       = bank_of(cur_q[`PSRTU_MODE_HI:`PSRTU_MODE_LO]);
    has_saved  = (bank != 3'd7);
    to_saved   = instr_i[`PSRTU_BIT_TARGET];
    flag_only  = ~instr_i[`PSRTU_BIT_FLAGONLY];
    user_mode  = (cur_q[`PSRTU_MODE_HI:`PSRTU_MODE_LO] == `PSRTU_MODE_USR);
    target_old = (to_saved && has_saved) ? saved_status_reg_q[bank] : cur_q;
    if (flag_only)
      write_mask = `PSRTU_FLAGS_MASK;
    else if (!to_saved && user_mode)
      write_mask = `PSRTU_FLAGS_MASK;
    else
      write_mask = `PSRTU_DEFINED_MASK;
    // flags take source bits 31..28 in N, Z, C, V order
    target_new = keep_defined((target_old & ~write_mask)
                              | (operand & write_mask));

    cur_d    = cur_q;
    saved_status_reg_d   = saved_status_reg_q;
    result_d = result_q;
    we_d     = 1'b0;
    ridx_d   = ridx_q;
    done_d   = 1'b0;
    ill_d    = 1'b0;

    if (mode_load_i)
    begin
      // exception entry path switches the mode field only
      cur_d[`PSRTU_MODE_HI:`PSRTU_MODE_LO] = mode_load_value_i;
    end
    else if (instr_valid_i && op != psrtu_pkg::PSRTU_OP_NONE)
    begin
      // every transfer retires in the cycle after it is presented
      done_d = 1'b1;
      if (to_saved && !has_saved)
        ill_d = 1'b1;
      else if (op == psrtu_pkg::PSRTU_OP_READ)
      begin
        result_d = target_old;
        we_d     = 1'b1;
        ridx_d   = instr_i[15:12];
      end
      else if (!form_ok)
        ill_d = 1'b1;
      else if (to_saved)
        saved_status_reg_d[bank] = target_new;
      else
        cur_d = target_new;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cur_q    <= `PSRTU_RESET_VALUE;
      for (int k = 0; k < 5; k++)
        saved_status_reg_q[k] <= 32'h0000_0000;
      result_q <= 32'h0000_0000;
      we_q     <= 1'b0;
      ridx_q   <= 4'h0;
      done_q   <= 1'b0;
      ill_q    <= 1'b0;
    end
    else
    begin
      cur_q    <= cur_d;
      saved_status_reg_q   <= saved_status_reg_d;
      result_q <= result_d;
      we_q     <= we_d;
      ridx_q   <= ridx_d;
      done_q   <= done_d;
      ill_q    <= ill_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic [31:0] saved_view_q;
  logic [3:0]  src_idx_q;

  // registered copies keep every output straight from a flop
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      saved_view_q <= 32'h0000_0000;
      src_idx_q    <= 4'h0;
    end
    else
    begin
      saved_view_q <= has_saved ? saved_status_reg_q[bank] : 32'h0000_0000;
      src_idx_q    <= src_index;
    end
  end

  assign current_status_reg_o = cur_q;
  assign saved_status_reg_o   = saved_view_q;
  assign mode_o               = cur_q[`PSRTU_MODE_HI:`PSRTU_MODE_LO];
  assign reg_index_o          = src_idx_q;
  assign result_o             = result_q;
  assign result_we_o          = we_q;
  assign result_index_o       = ridx_q;
  assign done_o               = done_q;
  assign illegal_o            = ill_q;

endmodule // psr_transfer_unit
`default_nettype wire

// ---- verilog/psrtu_operand.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "psrtu_params.svh"

// ****************************************************************
// source operand select for the status write
// ****************************************************************
module psrtu_operand
(
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] reg_value_i,
  output logic      [31:0] operand_o,
  output logic      [3:0]  reg_index_o,
  output logic             form_ok_o
);

  function automatic logic [31:0] rotr(input logic [31:0] v,
                                       input logic [4:0]  s);
    rotr = (v >> s) | (v << (6'd32 - {1'b0, s}));
  endfunction

  always_comb
  begin
    reg_index_o = instr_i[3:0];
    if (instr_i[`PSRTU_BIT_IMM])
    begin
      // rotate right by twice the four-bit field
      operand_o = rotr({24'h00_0000, instr_i[7:0]},
                       {instr_i[11:8], 1'b0});
      form_ok_o = 1'b1;
    end
    else
    begin
      operand_o = reg_value_i;
      form_ok_o = (instr_i[11:4] == 8'h00);
    end
  end

endmodule // psrtu_operand
`default_nettype wire

// ---- verilog/psrtu_params.svh ----
`ifndef PSRTU_PARAMS_SVH
`define PSRTU_PARAMS_SVH

// ****************************************************************
// status register layout
// ****************************************************************
`define PSRTU_FLAG_N        31
`define PSRTU_FLAG_Z        30
`define PSRTU_FLAG_C        29
`define PSRTU_FLAG_V        28
`define PSRTU_CTRL_I        7
`define PSRTU_CTRL_F        6
`define PSRTU_CTRL_T        5
`define PSRTU_MODE_HI       4
`define PSRTU_MODE_LO       0
`define PSRTU_FLAGS_MASK    32'hF000_0000
`define PSRTU_DEFINED_MASK  32'hF000_00FF
`define PSRTU_MODE_MASK     32'h0000_001F

// ****************************************************************
// mode codes and reset value
// ****************************************************************
`define PSRTU_MODE_USR      5'h10
`define PSRTU_MODE_FIQ      5'h11
`define PSRTU_MODE_IRQ      5'h12
`define PSRTU_MODE_SVC      5'h13
`define PSRTU_MODE_ABT      5'h17
`define PSRTU_MODE_UND      5'h1B
`define PSRTU_MODE_SYS      5'h1F
`define PSRTU_RESET_VALUE   32'h0000_00D3

// ****************************************************************
// instruction fields
// ****************************************************************
`define PSRTU_BIT_TARGET    22
`define PSRTU_BIT_IMM       25
`define PSRTU_BIT_FLAGONLY  16
`define PSRTU_CYCLE_COUNT   1

`endif

// ---- verilog/psrtu_pkg.sv ----
`default_nettype none
package psrtu_pkg;

  typedef enum logic [1:0] {
    PSRTU_OP_NONE,
    PSRTU_OP_READ,
    PSRTU_OP_WRITE
  } psrtu_op_e;

  typedef logic [31:0] psrtu_word_t;

endpackage
`default_nettype wire
